/* File: verilog/xpbus_params.svh */
// Behaviour
// - access uses 3 address lines, 16 data lines, strobe, read/write select and wait input
// - seven 16-bit off-chip slots, 0 to 6, selected by address lines
// - slots 4-6 belong to internal peripherals, freed when owner disabled
// - access finishes in one cycle without programmed or external wait
// - one internal wait state inserted when selected in the config slot
// - wait input looked at only during an off-chip access
// - read/write select high for read, low for write
// - slot 7 only programs wait states, never appears on the pins
// - slot 4 belongs to the timer while timer enabled
// - slots 5 and 6 belong to codec channels 0 and 1 while enabled
`ifndef XPBUS_PARAMS_SVH
`define XPBUS_PARAMS_SVH
`define XPB_ADDR_W 3
`define XPB_DATA_W 16
`define XPB_SLOT_TIMER 3'h4
`define XPB_SLOT_CODEC0 3'h5
`define XPB_SLOT_CODEC1 3'h6
`define XPB_SLOT_WCFG 3'h7
`define XPB_WCFG_BIT 2
`define XPB_WCFG_RST 1'b0
`define XPB_RDATA_RST 16'h0000
`endif

/* File: verilog/xpbus_pkg.sv */
`include "xpbus_params.svh"
package xpbus_pkg;
  typedef logic [`XPB_ADDR_W-1:0] xpbus_addr_t;
  typedef logic [`XPB_DATA_W-1:0] xpbus_data_t;
  typedef enum logic [3:0] {
    XPB_IDLE = 4'h1,
    XPB_SETUP = 4'h2,
    XPB_STROBE = 4'h4,
    XPB_DONE = 4'h8
  } xpbus_state_t;
endpackage : xpbus_pkg

/* File: verilog/xpbus_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for the wait pin
module xpbus_sync (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic d,
  output logic q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;
  // release value high so no spurious stretch after reset
  always_comb
  begin
    meta_nxt = clk_en ? d : meta_r;
    q_nxt = clk_en ? meta_r : q;
  end
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end
    else
    begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule : xpbus_sync

/* File: verilog/xpbus_port.sv */
`timescale 1ns/1ps
`include "xpbus_params.svh"
// external peripheral register port
module xpbus_port (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic req,
  input wire logic req_read,
  input wire xpbus_pkg::xpbus_addr_t req_addr,
  input wire xpbus_pkg::xpbus_data_t req_wdata,
  input wire logic timer_enabled,
  input wire logic codec0_enabled,
  input wire logic codec1_enabled,
  input wire logic wait_n,
  input wire xpbus_pkg::xpbus_data_t peripheral_data_lines_in,
  output xpbus_pkg::xpbus_data_t peripheral_data_lines_out,
  output logic peripheral_data_lines_oe,
  output xpbus_pkg::xpbus_addr_t peripheral_address_lines,
  output logic data_strobe_n,
  output logic read_not_write,
  output logic busy,
  output logic done,
  output logic refused,
  output xpbus_pkg::xpbus_data_t rdata,
  output logic wait_state_en
);
  import xpbus_pkg::*;

  xpbus_state_t state_r, state_nxt;
  xpbus_addr_t addr_r, addr_nxt;
  xpbus_data_t wdata_r, wdata_nxt;
  xpbus_data_t rdata_nxt;
  xpbus_data_t din_m_r, din_r;
  logic rnw_r, rnw_nxt;
  logic oe_nxt, ds_nxt, busy_nxt, done_nxt, refused_nxt, wse_nxt;
  logic iwait_r, iwait_nxt;
  logic wait_s;
  logic slot_free;

  xpbus_sync u_wait_sync (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .d(wait_n),
    .q(wait_s)
  );

  // shared slots open only while their owner is disabled
  always_comb
  begin
    case (req_addr)
      `XPB_SLOT_TIMER: slot_free = !timer_enabled;
      `XPB_SLOT_CODEC0: slot_free = !codec0_enabled;
      `XPB_SLOT_CODEC1: slot_free = !codec1_enabled;
      `XPB_SLOT_WCFG: slot_free = 1'b0;
      default: slot_free = 1'b1;
    endcase
  end

  // access sequencer: setup, strobe low (stretched by waits), strobe rise
  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rnw_nxt = rnw_r;
    rdata_nxt = rdata;
    oe_nxt = peripheral_data_lines_oe;
    ds_nxt = data_strobe_n;
    busy_nxt = busy;
    done_nxt = 1'b0;
    refused_nxt = 1'b0;
    wse_nxt = wait_state_en;
    iwait_nxt = iwait_r;
    case (state_r)
      XPB_IDLE:
      begin
        if (req && req_addr == `XPB_SLOT_WCFG && !req_read)
        begin
          wse_nxt = req_wdata[`XPB_WCFG_BIT]; // internal only
          done_nxt = 1'b1;
        end
        else if (req && req_addr == `XPB_SLOT_WCFG)
        begin
          rdata_nxt = '0;
          rdata_nxt[`XPB_WCFG_BIT] = wait_state_en;
          done_nxt = 1'b1;
        end
        else if (req && !slot_free)
          refused_nxt = 1'b1;
        else if (req)
        begin
          addr_nxt = req_addr;
          wdata_nxt = req_wdata;
          rnw_nxt = req_read; // high read, low write
          oe_nxt = !req_read;
          busy_nxt = 1'b1;
          state_nxt = XPB_SETUP;
        end
      end
      XPB_SETUP:
      begin
        ds_nxt = 1'b0; // address and select already settled a cycle
        iwait_nxt = wait_state_en;
        state_nxt = XPB_STROBE;
      end
      XPB_STROBE:
      begin
        // wait pin only matters here, inside an access
        if (iwait_r)
          iwait_nxt = 1'b0; // exactly one extra cycle
        else if (wait_s)
        begin
          ds_nxt = 1'b1;
          state_nxt = XPB_DONE;
        end
      end
      XPB_DONE:
      begin
        // synced pin data lags two edges, so take it one edge after strobe rise;
        // taking it at the rise would return the word from before the address moved
        if (rnw_r)
          rdata_nxt = din_r;
        oe_nxt = 1'b0; // data held one cycle past strobe rise
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        state_nxt = XPB_IDLE;
      end
      default:
        state_nxt = XPB_IDLE;
    endcase
  end

  // registers; address and select held unchanged until idle
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= XPB_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      rnw_r <= 1'b1;
      rdata <= `XPB_RDATA_RST;
      peripheral_data_lines_oe <= 1'b0;
      data_strobe_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      wait_state_en <= `XPB_WCFG_RST;
      iwait_r <= 1'b0;
      din_m_r <= '0;
      din_r <= '0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rnw_r <= rnw_nxt;
      rdata <= rdata_nxt;
      peripheral_data_lines_oe <= oe_nxt;
      data_strobe_n <= ds_nxt;
      busy <= busy_nxt;
      done <= done_nxt;
      refused <= refused_nxt;
      wait_state_en <= wse_nxt;
      iwait_r <= iwait_nxt;
      din_m_r <= peripheral_data_lines_in;
      din_r <= din_m_r;
    end
  end

  assign peripheral_address_lines = addr_r;
  assign read_not_write = rnw_r;
  assign peripheral_data_lines_out = wdata_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_strobe_fall;
    clk_en && state_r == XPB_SETUP;
  endsequence

  // request taken for a pin access
  sequence s_pin_taken;
    clk_en && state_r == XPB_IDLE && req && slot_free;
  endsequence

  // request to a shared slot whose owner still holds it
  sequence s_slot_owned;
    clk_en && state_r == XPB_IDLE && req && !slot_free && req_addr != `XPB_SLOT_WCFG;
  endsequence

  // request to a codec slot while that channel is enabled
  sequence s_codec_owned;
    clk_en && state_r == XPB_IDLE && req && ((req_addr == `XPB_SLOT_CODEC0 && codec0_enabled)
      || (req_addr == `XPB_SLOT_CODEC1 && codec1_enabled));
  endsequence

  // request to the wait config slot
  sequence s_cfg_taken;
    clk_en && state_r == XPB_IDLE && req && req_addr == `XPB_SLOT_WCFG;
  endsequence

  AST_ADDR_LATCH: assert property (s_pin_taken |=> addr_r == $past(req_addr) && rnw_r == $past(req_read))
    else $error("address or select not latched");
  AST_REFUSE_QUIET: assert property (s_slot_owned |=> state_r == XPB_IDLE && data_strobe_n && !busy)
    else $error("owned slot started a pin access");
  AST_CODEC_SLOT: assert property (s_codec_owned |=> refused)
    else $error("codec slot not refused");
  AST_CFG_LOCAL: assert property (s_cfg_taken |=> state_r == XPB_IDLE && done && data_strobe_n)
    else $error("config slot access left the block");
  AST_READ_FLOAT: assert property (read_not_write |-> !peripheral_data_lines_oe)
    else $error("data driven during read");

  AST_ADDR_STABLE: assert property (!data_strobe_n && $past(!data_strobe_n) |-> $stable(addr_r))
    else $error("address moved while strobe low");
  AST_RNW_STABLE: assert property (!data_strobe_n |-> $stable(rnw_r))
    else $error("read select moved while strobe low");
  AST_NO_CFG_PIN: assert property (!data_strobe_n |-> addr_r != `XPB_SLOT_WCFG)
    else $error("config slot on pins");
  AST_SINGLE: assert property (s_strobe_fall ##1 (clk_en && !iwait_r && wait_s) |=> data_strobe_n)
    else $error("unstretched access not single cycle");
  AST_ONE_WAIT: assert property (s_strobe_fall ##1 (clk_en && iwait_r) |=> !data_strobe_n)
    else $error("internal wait not inserted");
  AST_WAIT_HOLD: assert property (clk_en && state_r == XPB_STROBE && !iwait_r && !wait_s |=> !data_strobe_n)
    else $error("strobe rose with wait low");
  AST_IDLE_WAIT: assert property (state_r == XPB_IDLE |-> data_strobe_n)
    else $error("strobe low outside access");
  AST_TIMER_SLOT: assert property (clk_en && state_r == XPB_IDLE && req
    && req_addr == `XPB_SLOT_TIMER && timer_enabled |=> refused)
    else $error("timer slot not refused");
  AST_WRITE_DRIVE: assert property (!data_strobe_n && !rnw_r |-> peripheral_data_lines_oe)
    else $error("write without data drive");
endmodule : xpbus_port

/* File: test/xpbus_periph.sv */
`timescale 1ns/1ps
// peripheral register latch on the far side
module xpbus_periph (
  input wire logic clock,
  input wire xpbus_pkg::xpbus_addr_t addr,
  input wire logic strobe_n,
  input wire logic rnw,
  input wire xpbus_pkg::xpbus_data_t dev_data,
  input wire logic dev_oe,
  input wire logic [3:0] wait_len,
  input wire logic idle_low,
  output xpbus_pkg::xpbus_data_t bus_data,
  output logic wait_n
);
  import xpbus_pkg::*;
  xpbus_data_t mem_r [0:7];
  xpbus_data_t last_r = 16'h0000;
  logic [3:0] cnt_r = 4'h0;
  logic strobe_d_r = 1'b1;
  // undriven bus toggles so stale data never passes
  assign bus_data = dev_oe ? dev_data : (rnw ? mem_r[addr] : ~last_r);
  // slow peripheral keeps wait low until its count after strobe fall runs out;
  // the port syncs wait through two flops, so it must already be low at address setup
  assign wait_n = !(idle_low || (wait_len != 4'h0 && (strobe_d_r || cnt_r != 4'h0)));
  // latch writes, start wait count at strobe fall
  always @(posedge clock)
  begin
    last_r <= bus_data;
    strobe_d_r <= strobe_n;
    if (!strobe_n && !rnw && dev_oe)
      mem_r[addr] <= dev_data;
    if (strobe_d_r && !strobe_n)
      cnt_r <= wait_len;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule : xpbus_periph

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
  import xpbus_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic rd = 1'b0;
  logic ten = 1'b0;
  logic c0en = 1'b0;
  logic c1en = 1'b0;
  logic idle_low = 1'b0;
  logic ce = 1'b1;
  logic bsy;
  logic [3:0] wlen = 4'h0;
  xpbus_addr_t ra = 3'h0;
  xpbus_addr_t pa;
  xpbus_data_t wd = 16'h0000;
  xpbus_data_t bin, dout, rdata;
  logic wait_n, oe, sn, rnw, done, refd, wse;
  int n_errors = 0;
  int checked = 0;
  int n;
  xpbus_port xpbus_port_i (.clock(clock), .reset(reset), .clk_en(ce), .req(req), .req_read(rd),
    .req_addr(ra), .req_wdata(wd), .timer_enabled(ten), .codec0_enabled(c0en), .codec1_enabled(c1en),
    .wait_n(wait_n), .peripheral_data_lines_in(bin), .peripheral_data_lines_out(dout),
    .peripheral_data_lines_oe(oe), .peripheral_address_lines(pa), .data_strobe_n(sn),
    .read_not_write(rnw), .busy(bsy), .done(done), .refused(refd), .rdata(rdata), .wait_state_en(wse));
  xpbus_periph xpbus_periph_i (.clock(clock), .addr(pa), .strobe_n(sn), .rnw(rnw), .dev_data(dout),
    .dev_oe(oe), .wait_len(wlen), .idle_low(idle_low), .bus_data(bin), .wait_n(wait_n));
  // clock, 100 ns period
  always #50 clock = ~clock;
  task stop_test;
    $display("errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task chk(input xpbus_data_t got, input xpbus_data_t exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one access; n = cycles until done or refused
  task acc(input logic r, input xpbus_addr_t a, input xpbus_data_t d);
    @(posedge clock);
    req <= 1'b1;
    rd <= r;
    ra <= a;
    wd <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      req <= 1'b0;
      #1 n++;
    end while (done !== 1'b1 && refd !== 1'b1 && n < 40);
  endtask : acc
  task t_rw;
    for (int i = 0; i < 7; i++)
    begin
      acc(1'b0, i[2:0], 16'h5A30 ^ 16'(i));
      chk(16'(n), 16'h0004);
    end
    for (int i = 0; i < 7; i++)
    begin
      acc(1'b1, i[2:0], 16'h0000);
      chk(rdata, 16'h5A30 ^ 16'(i));
    end
  endtask : t_rw
  task t_ws;
    acc(1'b0, 3'h7, 16'h0004);
    chk(16'(n), 16'h0001);
    acc(1'b1, 3'h7, 16'h0000);
    chk({15'h0, rdata[2]}, 16'h0001);
    acc(1'b1, 3'h1, 16'h0000);
    chk(16'(n), 16'h0005);
    acc(1'b0, 3'h7, 16'h0000);
    chk({15'h0, wse}, 16'h0000);
  endtask : t_ws
  task t_wait;
    wlen <= 4'h3;
    acc(1'b1, 3'h2, 16'h0000);
    chk({15'h0, n >= 6 && n <= 11}, 16'h0001);
    chk(rdata, 16'h5A32);
    wlen <= 4'h0;
    idle_low <= 1'b1;
    repeat (6) @(posedge clock);
    idle_low <= 1'b0;
    #1 chk({14'h0, sn, done}, 16'h0002);
    repeat (3) @(posedge clock);
    acc(1'b1, 3'h3, 16'h0000);
    chk(16'(n), 16'h0004);
  endtask : t_wait
  // freeze the port mid-strobe; pins must hold, then the read completes
  task t_ce;
    @(posedge clock);
    req <= 1'b1;
    rd <= 1'b1;
    ra <= 3'h0;
    @(posedge clock);
    req <= 1'b0;
    @(posedge clock);
    ce <= 1'b0;
    repeat (5) @(posedge clock);
    ce <= 1'b1;
    #1 chk({11'h0, bsy, sn, pa}, 16'h0010);
    n = 0;
    do
    begin
      @(posedge clock);
      #1 n++;
    end while (done !== 1'b1 && n < 40);
    chk(16'(n), 16'h0002);
    chk(rdata, 16'h5A30);
  endtask : t_ce
  task t_own;
    ten <= 1'b1;
    c0en <= 1'b1;
    c1en <= 1'b1;
    for (int a = 4; a < 7; a++)
    begin
      acc(1'b1, a[2:0], 16'h0000);
      chk({15'h0, refd}, 16'h0001);
    end
  endtask : t_own
  // slot 7 must never reach the pins
  always @(negedge clock)
    if (sn === 1'b0 && pa === 3'h7)
      chk({13'h0, pa}, 16'h0000);
  // main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_rw;
    t_ws;
    t_wait;
    t_ce;
    t_own;
    stop_test;
  end
  // hang guard, far above the hundred-odd cycles used
  initial
  begin
    #500000;
    n_errors++;
    stop_test;
  end
endmodule : tb
